/* File: hdl/supply_reset_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] hold reset until supply good plus timeout
// [RULE2] release open-drain reset outputs after timeout
// [RULE3] assert reset within 5 us of trip
// [RULE4] ignore supply dips up to 30 ns
// [RULE5] falling edge on reset pin restarts timeout
// [RULE6] short external reset still gives full timeout
// [RULE7] pushbutton asserts reset, holds plus timeout
// [RULE8] pushbutton ignores under 100 ns pulses
// [RULE9] reset aborts and refuses memory transfers
// [RULE10] reset blocks new program cycle, not running
// [RULE11] program cycle finishes within 5 ms
// [RULE12] bus disabled and data released while programming
// [RULE13] write protect refuses all programming
// [RULE14] suppress 100 ns spikes on bus inputs
// [RULE15] master waits after power-up before access
// [RULE16] master leaves bus idle after stop
// [RULE17] both reset outputs from one state
// [RULE18] all intervals counted from internal clock
module supply_reset_supervisor
    import supervisor_pkg::*;
#(
    parameter longint unsigned TIMEOUT_CYC = RESET_TIMEOUT_CYC,
    parameter longint unsigned PROGRAM_CYC = PROGRAM_CYCLE_CYC
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic supply_good_i,
    input wire logic pushbutton_reset_n_i,
    input wire logic reset_n_pin_i,
    input wire logic write_protect_i,
    input wire logic bus_clk_i,
    input wire logic bus_data_i,
    input wire logic program_request_i,
    output logic reset_n_pin_o,
    output logic reset_n_pin_oe_o,
    output logic reset_high_o,
    output logic reset_high_oe_o,
    output logic bus_clk_filt_o,
    output logic bus_data_filt_o,
    output logic bus_enable_o,
    output logic bus_abort_o,
    output logic program_busy_o,
    output logic program_refused_o
);
    // ------------------------------------------------------------
    // input filters
    // ------------------------------------------------------------
    logic supply_ok;
    logic pushbutton_n;
    logic pin_n;
    logic bus_clk_f;
    logic bus_data_f;
    logic write_protect;

    glitch_filter #(.FILT_CYC(SUPPLY_FILT_CYC), .RESET_LEVEL(1'b0)) u_supply_filt ( // RULE4
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .raw_i(supply_good_i),
        .level_o(supply_ok)
    );

    glitch_filter #(.FILT_CYC(PUSHBUTTON_FILT_CYC), .RESET_LEVEL(1'b1)) u_button_filt ( // RULE8
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .raw_i(pushbutton_reset_n_i),
        .level_o(pushbutton_n)
    );

    // short filter on the pin only; the edge is what matters
    glitch_filter #(.FILT_CYC(2), .RESET_LEVEL(1'b1)) u_pin_filt (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .raw_i(reset_n_pin_i),
        .level_o(pin_n)
    );

    glitch_filter #(.FILT_CYC(BUS_FILT_CYC), .RESET_LEVEL(1'b1)) u_scl_filt ( // RULE14
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .raw_i(bus_clk_i),
        .level_o(bus_clk_f)
    );

    glitch_filter #(.FILT_CYC(BUS_FILT_CYC), .RESET_LEVEL(1'b1)) u_sda_filt ( // RULE14
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .raw_i(bus_data_i),
        .level_o(bus_data_f)
    );

    // the protect strap is a pin too; while in reset it reads as protected, the safe side
    glitch_filter #(.FILT_CYC(1), .RESET_LEVEL(1'b1)) u_wp_filt ( // RULE13
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .raw_i(write_protect_i),
        .level_o(write_protect)
    );

    // ------------------------------------------------------------
    // reset pin edge detect
    // ------------------------------------------------------------
    logic pin_prev;
    logic pin_fall;
    logic in_reset;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_prev <= 1'b1;
        end else begin
            pin_prev <= pin_n;
        end
    end

    // our own drive reads back low, so only an edge while released counts
    assign pin_fall = pin_prev && !pin_n && !in_reset; // RULE5

    // ------------------------------------------------------------
    // reset state machine
    // ------------------------------------------------------------
    supervisor_state_e state;
    supervisor_state_e next_state;
    logic [TIMER_W-1:0] timer;
    logic timer_done;
    logic hold_cond;

    assign hold_cond = !supply_ok || !pushbutton_n; // RULE1 RULE3 RULE7
    assign timer_done = (timer >= TIMER_W'(TIMEOUT_CYC - 1)); // RULE18

    always_comb begin
        next_state = state;
        case (state)
            SUP_HOLD: begin
                if (!hold_cond) begin
                    next_state = SUP_TIMEOUT;
                end
            end
            SUP_TIMEOUT: begin
                if (hold_cond) begin
                    next_state = SUP_HOLD;
                end else if (timer_done) begin
                    next_state = SUP_RUN; // RULE1
                end
            end
            SUP_RUN: begin
                if (hold_cond) begin
                    next_state = SUP_HOLD; // RULE3 RULE7
                end else if (pin_fall) begin
                    next_state = SUP_TIMEOUT; // RULE5 RULE6
                end
            end
            default: begin
                next_state = SUP_HOLD;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= SUP_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // timer restarts on every entry into the timeout state
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer <= '0;
        end else if (next_state != SUP_TIMEOUT || state != SUP_TIMEOUT) begin
            timer <= '0; // RULE6
        end else begin
            timer <= timer + 1'b1;
        end
    end

    // one decode for every place that asks whether reset is being driven
    function automatic logic drives_reset(input supervisor_state_e s);
        return (s != SUP_RUN);
    endfunction

    assign in_reset = drives_reset(state);

    // ------------------------------------------------------------
    // reset outputs: open drain, one source for both
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reset_n_pin_o <= 1'b0;
            reset_n_pin_oe_o <= RESET_ACTIVE_AT_RESET;
            reset_high_o <= 1'b1;
            reset_high_oe_o <= RESET_ACTIVE_AT_RESET;
        end else begin
            reset_n_pin_o <= 1'b0; // RULE17
            reset_high_o <= 1'b1; // RULE17
            reset_n_pin_oe_o <= drives_reset(next_state); // RULE2 RULE17
            reset_high_oe_o <= drives_reset(next_state); // RULE2 RULE17
        end
    end

    // ------------------------------------------------------------
    // memory gating
    // ------------------------------------------------------------
    logic prog_start;
    logic prog_busy;
    memory_gate_s gate;

    // a request while in reset or protected is dropped, never queued
    assign prog_start = program_request_i && !in_reset && !write_protect; // RULE10 RULE13

    program_cycle_timer #(.CYCLES(PROGRAM_CYC)) u_prog ( // RULE11
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .start_i(prog_start),
        .busy_o(prog_busy),
        .done_o()
    );

    assign gate.in_reset = in_reset;
    assign gate.program_busy = prog_busy;
    assign gate.bus_enable = !in_reset && !prog_busy; // RULE9 RULE12

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_enable_o <= 1'b0;
            bus_abort_o <= 1'b0;
            program_busy_o <= 1'b0;
            program_refused_o <= 1'b0;
            bus_clk_filt_o <= 1'b1;
            bus_data_filt_o <= 1'b1;
        end else begin
            bus_enable_o <= gate.bus_enable; // RULE9 RULE12
            // one pulse as reset takes hold, so a transfer underway is dropped
            bus_abort_o <= gate.in_reset && bus_enable_o; // RULE9
            program_busy_o <= gate.program_busy; // RULE10
            program_refused_o <= program_request_i && (in_reset || write_protect) && !prog_busy; // RULE13
            bus_clk_filt_o <= bus_clk_f; // RULE14
            bus_data_filt_o <= bus_data_f; // RULE14
        end
    end
endmodule

`default_nettype wire

/* File: hdl/supervisor_pkg.sv */
package supervisor_pkg;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;

    // ------------------------------------------------------------
    // documented times, in their own units
    // ------------------------------------------------------------
    localparam longint unsigned RESET_TIMEOUT_MS = 200;
    localparam longint unsigned RESET_TIMEOUT_MIN_MS = 130;
    localparam longint unsigned RESET_TIMEOUT_MAX_MS = 270;
    localparam longint unsigned TRIP_TO_RESET_DELAY_US = 5;
    localparam longint unsigned SUPPLY_DIP_REJECT_WIDTH_NS = 30;
    localparam longint unsigned PUSHBUTTON_GLITCH_NS = 100;
    localparam longint unsigned PUSHBUTTON_MIN_PULSE_US = 5;
    localparam longint unsigned PUSHBUTTON_TO_RESET_DELAY_US = 1;
    localparam longint unsigned PROGRAM_CYCLE_TIME_MS = 5;
    localparam longint unsigned BUS_SPIKE_NS = 100;
    localparam longint unsigned BUS_IDLE_GAP_NS = 1300;
    localparam longint unsigned POWERUP_TO_WRITE_WAIT_MS = 270;

    // ------------------------------------------------------------
    // cycle counts derived from the clock
    // ------------------------------------------------------------
    // least times round up
    localparam longint unsigned RESET_TIMEOUT_CYC =
        (RESET_TIMEOUT_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // filters reject anything up to the width plus one cycle of margin
    localparam int unsigned SUPPLY_FILT_CYC =
        int'((SUPPLY_DIP_REJECT_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) + 1;
    localparam int unsigned PUSHBUTTON_FILT_CYC =
        int'((PUSHBUTTON_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) + 1;
    localparam int unsigned BUS_FILT_CYC =
        int'((BUS_SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) + 1;
    // longest time rounds down; program cycle ends within it
    localparam longint unsigned PROGRAM_CYCLE_CYC =
        (PROGRAM_CYCLE_TIME_MS * 1000000000) / CLK_PERIOD_PS;

    localparam int unsigned TIMER_W = 27;
    localparam int unsigned FILT_W = 6;

    // ------------------------------------------------------------
    // reset values and grouped signals
    // ------------------------------------------------------------
    localparam logic RESET_ACTIVE_AT_RESET = 1'b1;

    typedef enum logic [1:0] {
        SUP_HOLD,
        SUP_TIMEOUT,
        SUP_RUN
    } supervisor_state_e;

    typedef struct packed {
        logic in_reset;
        logic program_busy;
        logic bus_enable;
    } memory_gate_s;

endpackage

/* File: hdl/glitch_filter.sv */
`timescale 1ns/1ps
`default_nettype none

// three flops of synchroniser, then a level must stand FILT_CYC + 1 cycles to pass
module glitch_filter #(
    parameter int unsigned FILT_CYC = 2,
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic raw_i,
    output logic level_o
);
    logic sync1;
    logic sync2;
    logic sync3;
    logic [7:0] count;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1 <= RESET_LEVEL;
            sync2 <= RESET_LEVEL;
            sync3 <= RESET_LEVEL;
        end else begin
            sync1 <= raw_i;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= 8'h00;
            level_o <= RESET_LEVEL;
        end else if (sync2 != sync3 || sync3 == level_o) begin
            count <= 8'h00;
        end else if (count >= 8'(FILT_CYC - 1)) begin
            count <= 8'h00;
            level_o <= sync3;
        end else begin
            count <= count + 8'h01;
        end
    end
endmodule

`default_nettype wire

/* File: hdl/program_cycle_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// internal program cycle; once started it cannot be cut short
module program_cycle_timer
    import supervisor_pkg::*;
#(
    parameter longint unsigned CYCLES = PROGRAM_CYCLE_CYC
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    logic [TIMER_W-1:0] count;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            count <= '0;
        end else begin
            done_o <= 1'b0;
            if (busy_o) begin
                if (count >= TIMER_W'(CYCLES - 1)) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    count <= '0;
                end else begin
                    count <= count + 1'b1;
                end
            end else if (start_i) begin
                busy_o <= 1'b1;
                count <= '0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: bench/supervisor_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module supervisor_monitor #(
    parameter longint unsigned TIMEOUT_CYC = 100,
    parameter longint unsigned PROGRAM_CYC = 50
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic supply_good_i,
    input wire logic pushbutton_reset_n_i,
    input wire logic reset_n_pin_i,
    input wire logic write_protect_i,
    input wire logic program_request_i,
    input wire logic reset_n_pin_o,
    input wire logic reset_n_pin_oe_o,
    input wire logic reset_high_o,
    input wire logic reset_high_oe_o,
    input wire logic bus_enable_o,
    input wire logic bus_abort_o,
    input wire logic program_busy_o,
    input wire logic program_refused_o
);
    // --------------------
    // helper counters
    // --------------------
    // held restarts on every reset cause, so release is timed from the last one
    longint unsigned held;
    int unsigned pb_low;
    longint unsigned busy_len;
    logic pin_q;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            held <= 0;
            pb_low <= 0;
            busy_len <= 0;
            pin_q <= 1'b1;
        end else begin
            held <= (!supply_good_i || !pushbutton_reset_n_i || (pin_q && !reset_n_pin_i)) ? 0 : held + 1;
            pb_low <= pushbutton_reset_n_i ? 0 : pb_low + 1;
            busy_len <= program_busy_o ? busy_len + 1 : 0;
            pin_q <= reset_n_pin_i;
        end
    end
    // --------------------
    // properties
    // --------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_pair; reset_n_pin_oe_o == reset_high_oe_o && !reset_n_pin_o && reset_high_o; endproperty
    a_pair: assert property (p_pair) else $error("reset outputs disagree");
    property p_trip; $fell(supply_good_i) ##1 !supply_good_i [*8] |-> ##[0:1000] reset_n_pin_oe_o; endproperty
    a_trip: assert property (p_trip) else $error("late trip reset");
    property p_release; $fell(reset_n_pin_oe_o) |-> held >= TIMEOUT_CYC && held <= TIMEOUT_CYC + 40; endproperty
    a_release: assert property (p_release) else $error("release off timeout");
    property p_button; pb_low == 200 |-> reset_n_pin_oe_o; endproperty
    a_button: assert property (p_button) else $error("button reset missing");
    property p_gate; reset_n_pin_oe_o ##1 reset_n_pin_oe_o |-> !bus_enable_o; endproperty
    a_gate: assert property (p_gate) else $error("bus open in reset");
    property p_abort; bus_abort_o |=> !bus_abort_o && !bus_enable_o; endproperty
    a_abort: assert property (p_abort) else $error("bad abort");
    // the protect strap passes a synchroniser, so only a settled level is judged
    property p_refuse; program_request_i && write_protect_i && $past(write_protect_i, 8) && bus_enable_o
        |=> program_refused_o ##1 !program_busy_o; endproperty
    a_refuse: assert property (p_refuse) else $error("protected write ran");
    property p_start; program_request_i && !write_protect_i && !$past(write_protect_i, 8) && bus_enable_o
        |-> ##2 program_busy_o && !bus_enable_o; endproperty
    a_start: assert property (p_start) else $error("program start wrong");
    property p_length; $fell(program_busy_o) |-> busy_len + 1 >= PROGRAM_CYC && busy_len <= PROGRAM_CYC + 1; endproperty
    a_length: assert property (p_length) else $error("program length wrong");
    c_program: cover property ($fell(program_busy_o));
    c_refused: cover property (program_refused_o);
    c_abort: cover property (bus_abort_o);
endmodule

bind supply_reset_supervisor supervisor_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC), .PROGRAM_CYC(PROGRAM_CYC))
    u_monitor (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .supply_good_i(supply_good_i),
    .pushbutton_reset_n_i(pushbutton_reset_n_i),
    .reset_n_pin_i(reset_n_pin_i),
    .write_protect_i(write_protect_i),
    .program_request_i(program_request_i),
    .reset_n_pin_o(reset_n_pin_o),
    .reset_n_pin_oe_o(reset_n_pin_oe_o),
    .reset_high_o(reset_high_o),
    .reset_high_oe_o(reset_high_oe_o),
    .bus_enable_o(bus_enable_o),
    .bus_abort_o(bus_abort_o),
    .program_busy_o(program_busy_o),
    .program_refused_o(program_refused_o)
);

`default_nettype wire

/* File: bench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// pull-up on the active-low line, pull-down on the active-high one
module host_model (
    input wire logic clk_i,
    input wire logic pin_oe_i,
    input wire logic high_oe_i,
    input wire logic hold_low_i,
    input wire logic go_i,
    input wire logic rude_i,
    output logic pin_o,
    output logic high_o,
    output logic req_o
);
    int idle;
    assign pin_o = !(pin_oe_i || hold_low_i);
    assign high_o = high_oe_i;
    // rude skips the waits so a scenario can reach a device still in reset
    always @(posedge clk_i) begin
        idle <= (high_o || req_o) ? 0 : idle + 1;
        req_o <= go_i && !req_o && (rude_i || idle > 260);
    end
endmodule

`default_nettype wire

/* File: bench/supply_reset_supervisor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module supply_reset_supervisor_tb_top;
    localparam int TO = 100;
    localparam int PC = 50;
    logic clk = 1'b0;
    logic nrst, sup, pb, wp, bl, hold, go, rude;
    logic oe, oeh, pno, rho, cf, df, be, ab, busy, rf, pin, rhi, req;
    int n_fail, n_tests, n, seed, k, n_ab, n_rf, n_sf;

    always #2.5 clk = ~clk;

    supply_reset_supervisor #(.TIMEOUT_CYC(TO), .PROGRAM_CYC(PC)) u_dut (
        .core_clk_i(clk), .nrst_i(nrst), .supply_good_i(sup), .pushbutton_reset_n_i(pb),
        .reset_n_pin_i(pin), .write_protect_i(wp), .bus_clk_i(bl), .bus_data_i(bl),
        .program_request_i(req), .reset_n_pin_o(pno), .reset_n_pin_oe_o(oe), .reset_high_o(rho),
        .reset_high_oe_o(oeh), .bus_clk_filt_o(cf), .bus_data_filt_o(df), .bus_enable_o(be),
        .bus_abort_o(ab), .program_busy_o(busy), .program_refused_o(rf));

    host_model u_host (.clk_i(clk), .pin_oe_i(oe), .high_oe_i(oeh), .hold_low_i(hold),
        .go_i(go), .rude_i(rude), .pin_o(pin), .high_o(rhi), .req_o(req));

    always @(posedge clk) begin
        if (ab === 1'b1) n_ab <= n_ab + 1;
        if (rf === 1'b1) n_rf <= n_rf + 1;
        if (cf === 1'b0 || df === 1'b0) n_sf <= n_sf + 1;
    end
    // --------------------
    // tasks
    // --------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wt(input logic v);
        n = 0;
        while (oe !== v && n < 3000) begin
            cyc(1);
            n++;
        end
        if (oe !== v) n_fail++;
    endtask
    task automatic prog(input logic r);
        go = 1'b1;
        rude = r;
        k = n_rf;
        n = 0;
        while (req !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        if (req !== 1'b1) n_fail++;
        go = 1'b0;
        cyc(3);
        n = 3;
    endtask
    task automatic drain;
        while (busy === 1'b1 && n < 500) begin
            cyc(1);
            n++;
        end
        if (busy === 1'b1) n_fail++;
    endtask
    task automatic report_and_stop;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // --------------------
    // scenarios
    // --------------------
    initial begin
        seed = 71;
        {nrst, sup, pb, wp, bl, hold, go, rude} = 8'b01101000;
        cyc(5);
        chk({oe, oeh, be}, 3'b110);
        nrst = 1'b1;
        wt(0);
        chk(n >= TO && n <= TO + 40, 1);
        chk({pin, rhi, pno, rho}, 4'b1001);
        repeat (8) begin
            sup = 1'b0;
            cyc(1 + $unsigned($random(seed)) % 6);
            sup = 1'b1;
            cyc(30);
            chk(oe, 0);
        end
        sup = 1'b0;
        wt(1);
        chk(n <= 1000, 1);
        sup = 1'b1;
        wt(0);
        repeat (8) begin
            pb = 1'b0;
            cyc(1 + $unsigned($random(seed)) % 20);
            pb = 1'b1;
            cyc(40);
            chk(oe, 0);
        end
        k = n_ab;
        pb = 1'b0;
        wt(1);
        chk(n <= 200, 1);
        cyc(1000 - n);
        chk({oe, n_ab != k}, 2'b11);
        pb = 1'b1;
        wt(0);
        chk(n >= TO && n <= TO + 40, 1);
        // let the lagging readback of our own drive settle high first, or no edge is seen
        cyc(10);
        hold = 1'b1;
        cyc(10);
        hold = 1'b0;
        chk(oe, 1);
        wt(0);
        chk(n + 10 >= TO && n <= TO + 30, 1);
        repeat (8) begin
            k = n_sf;
            bl = 1'b0;
            cyc(1 + $unsigned($random(seed)) % 20);
            bl = 1'b1;
            cyc(40);
            chk(n_sf - k, 0);
        end
        bl = 1'b0;
        cyc(40);
        chk({cf, df}, 2'b00);
        bl = 1'b1;
        prog(0);
        chk({busy, be}, 2'b10);
        drain();
        chk(n >= PC - 2 && n <= PC + 4, 1);
        wp = 1'b1;
        prog(0);
        chk({busy, n_rf != k}, 2'b01);
        wp = 1'b0;
        pb = 1'b0;
        wt(1);
        prog(1);
        chk({busy, n_rf != k}, 2'b01);
        pb = 1'b1;
        wt(0);
        prog(0);
        pb = 1'b0;
        drain();
        chk({n >= PC - 2, oe}, 2'b11);
        pb = 1'b1;
        wt(0);
        report_and_stop();
    end
    // the whole run needs a few thousand cycles; this limit leaves wide margin
    initial begin
        #300000;
        n_fail++;
        report_and_stop();
    end
endmodule

`default_nettype wire
